//--- rtl/gtm_top.sv
// General timer module with two halves, a 32-bit timer and a clock-match counter.
// Assumes software keeps the half enable clear while it changes configuration,
// and that the module clock was enabled three cycles before the first access.
//
// Behaviour
// RULE_01: Software enables module clock before use.
// RULE_02: Software waits three clocks after enabling.
// RULE_03: Software clears enable before changing configuration.
// RULE_04: Configuration zero selects 32-bit timer.
// RULE_05: Mode one is one-shot, two periodic.
// RULE_06: One-shot stops at time-out; periodic continues.
// RULE_07: Time-out sets raw flag; write-one clears.
// RULE_08: Mask passes time-out to masked status, interrupt.
// RULE_09: Configuration one counts 32.768 kHz pin.
// RULE_10: Clock match sets raw flag, keeps counting.
// RULE_11: Clock match clear bit and mask bit.
// RULE_12: Configuration four splits into two halves.
// RULE_13: Prescaler applies in 16-bit timer modes.
// RULE_14: Capture select zero, mode three: edge count.
// RULE_15: Edge count reaches match, sets match flag.
// RULE_16: Edge count stops; restart needs reprogramming.
// RULE_17: Capture select one, mode three: edge time.
// RULE_18: Edge time event sets flag, latches count.
// RULE_19: Edge time load takes effect next cycle.
// RULE_20: Alternate select one, mode two: PWM.
// RULE_21: Level bit inverts PWM output.
// RULE_22: PWM runs continuously; load changes period next cycle.
// RULE_23: PWM asserts at start, drops at match.
// RULE_24: Halves keep independent counters and flags.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module gtm_top
    import gtm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ccp_a_in,
    input wire logic ccp_b_in,
    output logic ccp_a_out,
    output logic ccp_a_oe,
    output logic ccp_b_out,
    output logic ccp_b_oe,
    output logic timer_irq
);
    typedef struct packed {
        logic [2:0] cfg;
        logic [3:0] amode;
        logic [3:0] bmode;
        logic [15:0] ctl;
        logic [15:0] imr;
        logic [15:0] ris;
        logic [31:0] ailr;
        logic [15:0] bilr;
        logic [31:0] amatch;
        logic [15:0] bmatch;
        logic [7:0] apr;
        logic [7:0] bpr;
        logic [31:0] cnt32;
        logic [31:0] rdata;
    } gtm_top_s;
    gtm_top_s st;
    gtm_top_s next_st;

    logic split;
    logic mode32;
    logic clock32;
    assign split = st.cfg >= CFG_SPLIT_MIN; // [RULE_12]
    assign mode32 = st.cfg == CFG_32_TIMER; // [RULE_04]
    assign clock32 = st.cfg == CFG_32_CLOCK; // [RULE_09]

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = reg_wr && (reg_addr == ofs);
    endfunction

    logic a_rise;
    logic a_hit;
    logic b_hit;
    gtm_edge_detect u_edge_a (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(ccp_a_in),
        .sel(st.ctl[CTL_EVT_LO +: 2]),
        .rise(a_rise),
        .hit(a_hit)
    );
    gtm_edge_detect u_edge_b (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(ccp_b_in),
        .sel(st.ctl[CTL_B_SHIFT + CTL_EVT_LO +: 2]),
        .rise(),
        .hit(b_hit)
    );

    logic [15:0] a_count;
    logic [15:0] a_cap;
    logic [15:0] b_count;
    logic [15:0] b_cap;
    logic a_to;
    logic a_cm;
    logic a_ce;
    logic a_stop;
    logic a_pwm;
    logic b_to;
    logic b_cm;
    logic b_ce;
    logic b_stop;
    logic b_pwm;
    logic [15:0] a_load;
    logic [15:0] b_load;
    // A running half must count from a value written in this very cycle, not the held one.
    assign a_load = wr_at(OFS_AILR) ? reg_wdata[15:0] : st.ailr[15:0]; // [RULE_19] [RULE_22]
    assign b_load = wr_at(OFS_BILR) ? reg_wdata[15:0] : st.bilr; // [RULE_19] [RULE_22]

    // Each half has its own counter and events; only the shared registers join them.
    gtm_half u_half_a ( // [RULE_24]
        .sys_clk(sys_clk),
        .srst(srst),
        .active(split),
        .en(st.ctl[CTL_EN]),
        .mode(st.amode),
        .pwml(st.ctl[CTL_PWML]),
        .load(a_load),
        .load_wr(wr_at(OFS_AILR)),
        .match(st.amatch[15:0]),
        .prescale(st.apr),
        .edge_hit(a_hit),
        .count(a_count),
        .capture(a_cap),
        .timeout(a_to),
        .cmatch(a_cm),
        .cevent(a_ce),
        .auto_stop(a_stop),
        .pwm_out(a_pwm)
    );
    gtm_half u_half_b (
        .sys_clk(sys_clk),
        .srst(srst),
        .active(split),
        .en(st.ctl[CTL_B_SHIFT + CTL_EN]),
        .mode(st.bmode),
        .pwml(st.ctl[CTL_B_SHIFT + CTL_PWML]),
        .load(b_load),
        .load_wr(wr_at(OFS_BILR)),
        .match(st.bmatch),
        .prescale(st.bpr),
        .edge_hit(b_hit),
        .count(b_count),
        .capture(b_cap),
        .timeout(b_to),
        .cmatch(b_cm),
        .cevent(b_ce),
        .auto_stop(b_stop),
        .pwm_out(b_pwm)
    );

    // 32-bit timer and clock-match counter events.
    logic run32;
    logic to32;
    logic clk_hit;
    logic clk_tick;
    assign run32 = st.ctl[CTL_EN] && (mode32 || clock32);
    assign clk_tick = run32 && clock32 && st.ctl[CTL_CLK_EN] && a_rise; // [RULE_09]
    assign to32 = run32 && mode32 && !wr_at(OFS_AILR) && (st.cnt32 == '0) &&
        ((st.amode[1:0] == MODE_ONE_SHOT) || (st.amode[1:0] == MODE_PERIODIC));
    assign clk_hit = clk_tick && ((st.cnt32 + 32'h1) == st.amatch); // [RULE_10]

    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [15:0] mis;
    always_comb begin
        set_bits = '0;
        set_bits[ST_TO] = split ? a_to : to32; // [RULE_07]
        set_bits[ST_CM] = a_cm; // [RULE_15]
        set_bits[ST_CE] = a_ce; // [RULE_18]
        set_bits[ST_CLK] = clk_hit; // [RULE_10]
        set_bits[ST_B_SHIFT + ST_TO] = b_to;
        set_bits[ST_B_SHIFT + ST_CM] = b_cm;
        set_bits[ST_B_SHIFT + ST_CE] = b_ce;
        clr_bits = wr_at(OFS_ICR) ? reg_wdata[15:0] : '0; // [RULE_07] [RULE_11]
    end
    assign mis = st.ris & st.imr; // [RULE_08] [RULE_11]

    always_comb begin
        next_st = st;
        if (wr_at(OFS_CFG)) begin
            next_st.cfg = reg_wdata[2:0];
        end
        if (wr_at(OFS_AMODE)) begin
            next_st.amode = reg_wdata[3:0];
        end
        if (wr_at(OFS_BMODE)) begin
            next_st.bmode = reg_wdata[3:0];
        end
        if (wr_at(OFS_CTL)) begin
            next_st.ctl = reg_wdata[15:0];
        end
        if (wr_at(OFS_IMR)) begin
            next_st.imr = reg_wdata[15:0];
        end
        if (wr_at(OFS_AILR)) begin
            next_st.ailr = reg_wdata;
        end
        if (wr_at(OFS_BILR)) begin
            next_st.bilr = reg_wdata[15:0];
        end
        if (wr_at(OFS_AMATCH)) begin
            next_st.amatch = reg_wdata;
        end
        if (wr_at(OFS_BMATCH)) begin
            next_st.bmatch = reg_wdata[15:0];
        end
        if (wr_at(OFS_APR)) begin
            next_st.apr = reg_wdata[7:0];
        end
        if (wr_at(OFS_BPR)) begin
            next_st.bpr = reg_wdata[7:0];
        end

        // Hardware clears the enable on a stop; this beats a same-cycle software write.
        if (split && a_stop) begin
            next_st.ctl[CTL_EN] = 1'b0; // [RULE_06] [RULE_16]
        end
        if (split && b_stop) begin
            next_st.ctl[CTL_B_SHIFT + CTL_EN] = 1'b0;
        end
        if (mode32 && to32 && (st.amode[1:0] == MODE_ONE_SHOT)) begin
            next_st.ctl[CTL_EN] = 1'b0; // [RULE_06]
        end

        // Set wins over a clear in the same cycle.
        next_st.ris = (st.ris & ~clr_bits) | set_bits;

        if (!run32) begin
            if (clock32) begin
                next_st.cnt32 = '0;
            end else if (wr_at(OFS_AILR)) begin
                next_st.cnt32 = reg_wdata;
            end else if (!st.ctl[CTL_EN]) begin
                next_st.cnt32 = st.ailr;
            end
        end else if (clock32) begin
            if (clk_tick) begin
                next_st.cnt32 = st.cnt32 + 32'h1; // [RULE_10]
            end
        end else if (wr_at(OFS_AILR)) begin
            next_st.cnt32 = reg_wdata;
        end else if (to32) begin
            next_st.cnt32 = st.ailr;
        end else begin
            next_st.cnt32 = st.cnt32 - 32'h1;
        end

        next_st.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CFG: next_st.rdata = {29'h0, st.cfg};
                OFS_AMODE: next_st.rdata = {28'h0, st.amode};
                OFS_BMODE: next_st.rdata = {28'h0, st.bmode};
                OFS_CTL: next_st.rdata = {16'h0, st.ctl};
                OFS_IMR: next_st.rdata = {16'h0, st.imr};
                OFS_RIS: next_st.rdata = {16'h0, st.ris};
                OFS_MIS: next_st.rdata = {16'h0, mis};
                OFS_AILR: next_st.rdata = st.ailr;
                OFS_BILR: next_st.rdata = {16'h0, st.bilr};
                OFS_AMATCH: next_st.rdata = st.amatch;
                OFS_BMATCH: next_st.rdata = {16'h0, st.bmatch};
                OFS_APR: next_st.rdata = {24'h0, st.apr};
                OFS_BPR: next_st.rdata = {24'h0, st.bpr};
                OFS_ACNT: next_st.rdata = split ? {16'h0, st.amode[2] ? a_cap : a_count} : st.cnt32;
                OFS_BCNT: next_st.rdata = {16'h0, st.bmode[2] ? b_cap : b_count};
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
            st.ailr <= RST_LOAD32;
            st.bilr <= RST_LOAD16;
            st.amatch <= RST_LOAD32;
            st.bmatch <= RST_LOAD16;
            st.cnt32 <= RST_LOAD32;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign timer_irq = |mis; // [RULE_08]
    // Capture pins are inputs except where a split half's mode has bit 3 set, as it is for PWM.
    assign ccp_a_out = a_pwm;
    assign ccp_b_out = b_pwm;
    assign ccp_a_oe = split && st.amode[3];
    assign ccp_b_oe = split && st.bmode[3];

    chk_irq_follows: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_08]
        $rose(st.ris[ST_TO]) && st.imr[ST_TO] |-> timer_irq)
        else $error("masked time-out did not raise interrupt");

    chk_clear_works: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_07]
        wr_at(OFS_ICR) && reg_wdata[ST_TO] && !set_bits[ST_TO] |=> !st.ris[ST_TO])
        else $error("time-out clear had no effect");

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_07]
        set_bits[ST_TO] |=> st.ris[ST_TO])
        else $error("time-out event lost");

    chk_clock_runs: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_10]
        clk_hit && !wr_at(OFS_CTL) |=> st.ctl[CTL_EN] && st.cnt32 == $past(st.cnt32) + 32'h1)
        else $error("clock counter stopped at match");

    chk_clock_clear: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_11]
        wr_at(OFS_ICR) && reg_wdata[ST_CLK] && !clk_hit |=> !st.ris[ST_CLK])
        else $error("clock match clear had no effect");

    chk_oneshot32_stop: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_06]
        to32 && (st.amode[1:0] == MODE_ONE_SHOT) |=> !st.ctl[CTL_EN])
        else $error("32-bit one-shot kept running");

    chk_split_stop: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_16]
        split && a_cm |=> !st.ctl[CTL_EN] ##1 !a_cm)
        else $error("edge count did not stop at match");
endmodule
`default_nettype wire

//--- rtl/gtm_pkg.sv
// Package for the general timer module: register offsets, fields, reset values and mode encodings.
// Assumes a plain register port with 32-bit data and byte addresses.
package gtm_pkg;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_AMODE = 8'h04;
    localparam logic [7:0] OFS_BMODE = 8'h08;
    localparam logic [7:0] OFS_CTL = 8'h0c;
    localparam logic [7:0] OFS_IMR = 8'h18;
    localparam logic [7:0] OFS_RIS = 8'h1c;
    localparam logic [7:0] OFS_MIS = 8'h20;
    localparam logic [7:0] OFS_ICR = 8'h24;
    localparam logic [7:0] OFS_AILR = 8'h28;
    localparam logic [7:0] OFS_BILR = 8'h2c;
    localparam logic [7:0] OFS_AMATCH = 8'h30;
    localparam logic [7:0] OFS_BMATCH = 8'h34;
    localparam logic [7:0] OFS_APR = 8'h38;
    localparam logic [7:0] OFS_BPR = 8'h3c;
    localparam logic [7:0] OFS_ACNT = 8'h48;
    localparam logic [7:0] OFS_BCNT = 8'h4c;

    localparam logic [2:0] CFG_32_TIMER = 3'h0;
    localparam logic [2:0] CFG_32_CLOCK = 3'h1;
    localparam logic [2:0] CFG_SPLIT_MIN = 3'h4;

    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;

    // Event-type field encodings.
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;

    // Control register bit positions for one half; half B sits CTL_B_SHIFT higher.
    localparam int CTL_EN = 0;
    localparam int CTL_EVT_LO = 2;
    localparam int CTL_CLK_EN = 4;
    localparam int CTL_PWML = 6;
    localparam int CTL_B_SHIFT = 8;

    // Status and mask bit positions for one half; half B sits ST_B_SHIFT higher.
    localparam int ST_TO = 0;
    localparam int ST_CM = 1;
    localparam int ST_CE = 2;
    localparam int ST_CLK = 3;
    localparam int ST_B_SHIFT = 8;

    localparam logic [31:0] RST_LOAD32 = 32'hffff_ffff;
    localparam logic [15:0] RST_LOAD16 = 16'hffff;
endpackage

//--- rtl/gtm_edge_detect.sv
// Edge detector for one capture pin: two-flop synchroniser then edge select.
// Assumes the pin is asynchronous to sys_clk and holds each level for at least two cycles.
`timescale 1ns/1ns
`default_nettype none
module gtm_edge_detect
    import gtm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic rise,
    output logic hit
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } gtm_sync_s;
    gtm_sync_s st;
    gtm_sync_s next_st;

    always_comb begin
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    logic fall;
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
    assign hit = (sel == EVT_RISE) ? rise : (sel == EVT_FALL) ? fall : (sel == EVT_BOTH) ? (rise | fall) : 1'b0;
endmodule
`default_nettype wire

//--- rtl/gtm_half.sv
// One 16-bit timer half: one-shot, periodic, edge count, edge time and PWM.
// Assumes the parent gives it configuration fields and one-cycle load strobes.
`timescale 1ns/1ns
`default_nettype none
module gtm_half
    import gtm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic active,
    input wire logic en,
    input wire logic [3:0] mode,
    input wire logic pwml,
    input wire logic [WIDTH-1:0] load,
    input wire logic load_wr,
    input wire logic [WIDTH-1:0] match,
    input wire logic [7:0] prescale,
    input wire logic edge_hit,
    output logic [WIDTH-1:0] count,
    output logic [WIDTH-1:0] capture,
    output logic timeout,
    output logic cmatch,
    output logic cevent,
    output logic auto_stop,
    output logic pwm_out
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] cap;
        logic [7:0] pre;
        logic pwm;
        logic was_en;
    } gtm_half_s;
    gtm_half_s st;
    gtm_half_s next_st;

    logic is_cap;
    logic is_pwm;
    logic is_timer;
    logic run;
    logic tick;
    assign is_pwm = mode[3] & ~mode[2] & (mode[1:0] == MODE_PERIODIC); // [RULE_20]
    assign is_cap = ~mode[3] & (mode[1:0] == MODE_CAPTURE); // [RULE_14] [RULE_17]
    assign is_timer = ~is_pwm & ((mode[1:0] == MODE_ONE_SHOT) | (mode[1:0] == MODE_PERIODIC)); // [RULE_05]
    assign run = active & en;
    // Prescaler divides only the plain timer modes.
    assign tick = is_timer ? (st.pre == '0) : 1'b1; // [RULE_13]

    always_comb begin
        next_st = st;
        timeout = 1'b0;
        cmatch = 1'b0;
        cevent = 1'b0;
        auto_stop = 1'b0;
        next_st.was_en = run;
        if (!run) begin
            next_st.pre = prescale;
            next_st.pwm = 1'b1;
            // An idle half tracks its start value so enable starts from it.
            if (load_wr || !st.was_en) begin
                next_st.cnt = load;
            end
        end else if (load_wr) begin
            next_st.cnt = load; // [RULE_19] [RULE_22]
        end else if (is_cap && !mode[2]) begin
            if (edge_hit) begin
                if ((st.cnt - 1'b1) == match) begin
                    cmatch = 1'b1; // [RULE_15]
                    auto_stop = 1'b1; // [RULE_16]
                    next_st.cnt = load;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
        end else if (tick) begin
            next_st.pre = prescale;
            if (is_pwm) begin
                if (st.cnt == '0) begin
                    next_st.cnt = load;
                    next_st.pwm = 1'b1; // [RULE_23]
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                    if ((st.cnt - 1'b1) == match) begin
                        next_st.pwm = 1'b0; // [RULE_23]
                    end
                end
            end else if (st.cnt == '0) begin
                next_st.cnt = load;
                if (!is_cap) begin
                    timeout = 1'b1; // [RULE_07]
                    auto_stop = (mode[1:0] == MODE_ONE_SHOT); // [RULE_06]
                end
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end else begin
            next_st.pre = st.pre - 1'b1;
        end
        if (run && is_cap && mode[2] && edge_hit) begin
            next_st.cap = st.cnt; // [RULE_18]
            cevent = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '{cnt: '1, cap: '1, pre: '0, pwm: 1'b1, was_en: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign count = st.cnt;
    assign capture = st.cap;
    assign pwm_out = (st.pwm & active & is_pwm) ^ pwml; // [RULE_21]

    chk_oneshot_stop: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_06]
        timeout && (mode[1:0] == MODE_ONE_SHOT) |-> auto_stop)
        else $error("one-shot time-out did not stop the half");
    chk_pwm_quiet: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_23]
        is_pwm |-> !timeout && !cmatch && !cevent)
        else $error("status event raised in pwm mode");
    chk_load_next: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_19]
        run && load_wr |=> st.cnt == $past(load))
        else $error("interval load not applied next cycle");
    chk_capture_latch: assert property (@(posedge sys_clk) disable iff (srst) // [RULE_18]
        cevent |=> capture == $past(st.cnt))
        else $error("edge time capture value wrong");
endmodule
`default_nettype wire

//--- tb/gtm_pin_model.sv
// Far-side model of the two capture pins: edge trains and the slow clock-mode input.
// Assumes the bench calls toggle hierarchically and that sys_clk runs free.
`timescale 1ns/1ns
`default_nettype none
module gtm_pin_model #(
    parameter int HOLD = 4
) (
    input wire logic sys_clk,
    output logic pin_a,
    output logic pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // Each level stands HOLD cycles, so the synchroniser sees every edge; the same
    // train stands in for the slow clock on pin A, shortened to keep runs brief.
    task automatic toggle(input bit on_b, input int n);
        repeat (n) begin
            repeat (HOLD) @(posedge sys_clk);
            if (on_b) begin
                pin_b <= ~pin_b;
            end else begin
                pin_a <= ~pin_a;
            end
        end
        repeat (HOLD) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_gtm_top.sv
// Testbench for the general timer module: register tasks and one scenario per mode.
// Assumes gtm_top behind the plain register port and gtm_pin_model on the capture pins.
`timescale 1ns/1ns
`default_nettype none
module tb_gtm_top
    import gtm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic srst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic ccp_a_in;
    logic ccp_b_in;
    logic ccp_a_out;
    logic ccp_a_oe;
    logic ccp_b_out;
    logic ccp_b_oe;
    logic timer_irq;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] v, w, x, y;
    logic [7:0] ra [8] = '{OFS_CFG, OFS_CTL, OFS_AILR, OFS_BILR, OFS_AMATCH, OFS_BMATCH, OFS_RIS, 8'h10};
    logic [31:0] rv [8] = '{32'h0, 32'h0, RST_LOAD32, {16'h0, RST_LOAD16}, RST_LOAD32,
                            {16'h0, RST_LOAD16}, 32'h0, 32'h0};

    always #10 sys_clk = ~sys_clk;

    gtm_top dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ccp_a_in(ccp_a_in),
                 .ccp_b_in(ccp_b_in), .ccp_a_out(ccp_a_out), .ccp_a_oe(ccp_a_oe),
                 .ccp_b_out(ccp_b_out), .ccp_b_oe(ccp_b_oe), .timer_irq(timer_irq));

    gtm_pin_model #(.HOLD(4)) pins (.sys_clk(sys_clk), .pin_a(ccp_a_in), .pin_b(ccp_b_in));

    task automatic print_verdict();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic wait_irq(input int limit);
        for (int i = 0; i < limit && timer_irq !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        if (timer_irq !== 1'b1) begin
            fails++;
            $display("FAIL %0t interrupt never came", $time);
            print_verdict();
        end
    endtask

    // Counting high cycles over 20 cycles, a whole number of periods for each tested interval, makes the result independent of phase.
    task automatic highs(output logic [31:0] n);
        n = 32'h0;
        repeat (20) begin
            @(negedge sys_clk);
            n = n + {31'h0, ccp_b_out};
        end
    endtask

    initial begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        settle(3);
        srst <= 1'b0;
        settle(3);
        wr(8'h10, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], v);
            check(v, rv[i], "reset value");
        end
        wr(OFS_CFG, 32'h0);
        wr(OFS_AMODE, {30'h0, MODE_PERIODIC});
        wr(OFS_AILR, 32'h28);
        wr(OFS_IMR, 32'h1);
        wr(OFS_CTL, 32'h1);
        wait_irq(60);
        rd(OFS_MIS, v);
        check(v, 32'h1, "masked time-out");
        wr(OFS_ICR, 32'h1);
        rd(OFS_RIS, v);
        check(v, 32'h0, "time-out cleared");
        wait_irq(60);
        wr(OFS_CTL, 32'h0);
        wr(OFS_AMODE, {30'h0, MODE_ONE_SHOT});
        wr(OFS_AILR, 32'h28);
        wr(OFS_ICR, 32'h1);
        wr(OFS_CTL, 32'h1);
        wait_irq(60);
        wr(OFS_ICR, 32'h1);
        settle(100);
        rd(OFS_RIS, v);
        check(v, 32'h0, "one-shot stays stopped");
        check(timer_irq, 32'h0, "interrupt cleared");
        wr(OFS_CTL, 32'h0);
        wr(OFS_CFG, {29'h0, CFG_SPLIT_MIN});
        wr(OFS_AMODE, 32'h2);
        wr(OFS_BMODE, {30'h0, MODE_ONE_SHOT});
        wr(OFS_APR, 32'h1);
        wr(OFS_AILR, 32'hffff);
        wr(OFS_BILR, 32'h20);
        wr(OFS_CTL, 32'h101);
        settle(4);
        rd(OFS_ACNT, v);
        rd(OFS_BCNT, w);
        rd(OFS_ACNT, x);
        rd(OFS_BCNT, y);
        check(v - x, 32'h2, "half A ticks every other cycle");
        check(w - y, 32'h4, "half B ticks every cycle");
        settle(40);
        rd(OFS_RIS, v);
        check(v, 32'h100, "half B one-shot time-out");
        rd(OFS_CTL, v);
        check(v, 32'h1, "half B stopped, half A runs");
        wr(OFS_ICR, 32'h100);
        wr(OFS_CTL, 32'h0);
        wr(OFS_AMODE, {30'h0, MODE_CAPTURE});
        wr(OFS_CTL, {28'h0, EVT_BOTH, 2'h0});
        wr(OFS_AILR, 32'ha);
        wr(OFS_AMATCH, 32'h6);
        wr(OFS_IMR, 32'h2);
        wr(OFS_CTL, 32'hd);
        pins.toggle(1'b0, 3);
        rd(OFS_RIS, v);
        check(v, 32'h0, "three edges short of match");
        pins.toggle(1'b0, 1);
        rd(OFS_RIS, v);
        check(v, 32'h2, "fourth edge reaches match");
        check(timer_irq, 32'h1, "match interrupt");
        rd(OFS_CTL, v);
        check(v, 32'hc, "enable cleared by hardware");
        pins.toggle(1'b0, 2);
        rd(OFS_ACNT, v);
        check(v, 32'ha, "later edges ignored");
        wr(OFS_ICR, 32'h2);
        rd(OFS_RIS, v);
        check(v, 32'h0, "match status cleared");
        wr(OFS_CTL, 32'h0);
        wr(OFS_BMODE, 32'h7);
        wr(OFS_IMR, 32'h400);
        wr(OFS_CTL, 32'h400);
        wr(OFS_CTL, 32'h500);
        pins.toggle(1'b1, 1);
        rd(OFS_RIS, v);
        check(v, 32'h0, "rising edge not selected");
        pins.toggle(1'b1, 1);
        rd(OFS_RIS, v);
        check(v, 32'h400, "falling edge captured");
        check(timer_irq, 32'h1, "event interrupt");
        rd(OFS_BCNT, v);
        settle(6);
        rd(OFS_BCNT, w);
        check(w, v, "captured count holds");
        wr(OFS_ICR, 32'h400);
        rd(OFS_RIS, v);
        check(v, 32'h0, "event status cleared");
        wr(OFS_CTL, 32'h0);
        wr(OFS_BMODE, 32'ha);
        wr(OFS_BILR, 32'h9);
        wr(OFS_BMATCH, 32'h2);
        wr(OFS_CTL, 32'h100);
        settle(12);
        highs(v);
        check(v, 32'he, "high seven of ten cycles");
        check(ccp_b_oe, 32'h1, "pin driven");
        check({ccp_a_oe, ccp_a_out}, 32'h0, "half A pin idle");
        wr(OFS_CTL, 32'h0);
        wr(OFS_CTL, 32'h4000);
        wr(OFS_CTL, 32'h4100);
        settle(12);
        highs(v);
        check(v, 32'h6, "inverted output");
        wr(OFS_BILR, 32'h4);
        rd(OFS_BCNT, v);
        check(v, 32'h3, "new interval used next cycle");
        settle(12);
        highs(v);
        check(v, 32'hc, "shorter period while running");
        rd(OFS_RIS, v);
        check(v, 32'h0, "no status in pwm");
        wr(OFS_CTL, 32'h0);
        wr(OFS_CFG, {29'h0, CFG_32_CLOCK});
        wr(OFS_AMATCH, 32'h3);
        wr(OFS_IMR, 32'h0);
        wr(OFS_CTL, 32'h11);
        pins.toggle(1'b0, 8);
        rd(OFS_RIS, v);
        check(v, 32'h8, "clock match");
        check(timer_irq, 32'h0, "clock match masked off");
        wr(OFS_IMR, 32'h8);
        @(negedge sys_clk);
        check(timer_irq, 32'h1, "clock match unmasked");
        wr(OFS_ICR, 32'h8);
        rd(OFS_RIS, v);
        check(v, 32'h0, "clock match cleared");
        rd(OFS_ACNT, v);
        pins.toggle(1'b0, 8);
        rd(OFS_ACNT, w);
        check(w - v, 32'h4, "counting on past the match");
        print_verdict();
    end
endmodule
`default_nettype wire
